// *** core/adc_link_consts.vh ***
`ifndef ADC_LINK_CONSTS_VH
`define ADC_LINK_CONSTS_VH

// Timing
`define CLK_PERIOD_NS 4
`define CONVERT_START_TIME_NS 3200
`define CONVERT_START_CYCLES (`CONVERT_START_TIME_NS / `CLK_PERIOD_NS)
`define CONVERT_START_CNT_W 10

// Data widths
`define RESULT_W 16
`define CFG_W 2
`define CFG_CNT_W 2
`define BIT_CNT_W 5

// Register map, byte addresses
`define WB_ADR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESULT 8'h08
`define REG_COUNT 8'h0C

// Control fields
`define CTRL_TWO_CH_BIT 0
`define CTRL_CFG_SGL_BIT 1
`define CTRL_CFG_ODD_BIT 2
`define CTRL_RESET 3'h3

// Status fields
`define STAT_STATE_LSB 0
`define STAT_ACT_CFG_LSB 2
`define STAT_PEND_CFG_LSB 4
`define STAT_CFG_VALID_BIT 6
`define STAT_EARLY_BIT 7
`define STAT_SHORT_BIT 8
`define STAT_BITS_LSB 9

`endif

// *** core/pin_sync.v ***
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] pin_i,
  output reg [WIDTH-1:0] level_o,
  output reg [WIDTH-1:0] rise_o,
  output reg [WIDTH-1:0] fall_o
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
      // Change counts only once stages two and three agree
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          level_o[g] <= 1'b0;
          rise_o[g] <= 1'b0;
          fall_o[g] <= 1'b0;
        end else begin
          s1[g] <= pin_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          rise_o[g] <= 1'b0;
          fall_o[g] <= 1'b0;
          if (s2[g] == s3[g] && s3[g] != level_o[g]) begin
            level_o[g] <= s3[g];
            rise_o[g] <= s3[g];
            fall_o[g] <= ~s3[g];
          end
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// *** core/convert_start_engine.v ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_link_consts.vh"

module convert_start_engine (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire two_ch_i,
  input wire sgl_i,
  input wire odd_i,
  input wire [`RESULT_W-1:0] ch_zero_i,
  input wire [`RESULT_W-1:0] ch_one_i,
  output reg busy_o,
  output reg done_o,
  output reg [`RESULT_W-1:0] result_o
);
  reg [`CONVERT_START_CNT_W-1:0] cnt;
  reg [`RESULT_W-1:0] held_plus;
  reg [`RESULT_W-1:0] held_minus;
  reg [`RESULT_W-1:0] plus;
  reg [`RESULT_W-1:0] minus;
  wire [`RESULT_W:0] diff;

  // Input routing for the conversion being started
  always @* begin
    plus = ch_zero_i;
    minus = ch_one_i;
    if (two_ch_i && sgl_i) begin
      // (RQ11) One channel against ground
      plus = odd_i ? ch_one_i : ch_zero_i;
      minus = {`RESULT_W{1'b0}};
    end else if (two_ch_i && odd_i) begin
      // (RQ12) Reversed differential polarity
      plus = ch_one_i;
      minus = ch_zero_i;
    end
  end

  assign diff = {1'b0, held_plus} - {1'b0, held_minus};

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= {`CONVERT_START_CNT_W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= {`RESULT_W{1'b0}};
      held_plus <= {`RESULT_W{1'b0}};
      held_minus <= {`RESULT_W{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // Hold both inputs at the same instant
        held_plus <= plus;
        held_minus <= minus;
        busy_o <= 1'b1;
        cnt <= {`CONVERT_START_CNT_W{1'b0}};
      end else if (busy_o) begin
        if (cnt == `CONVERT_START_CYCLES - 1) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          // (RQ13) Zero at zero difference, negative clips to zero
          result_o <= diff[`RESULT_W] ? {`RESULT_W{1'b0}} : diff[`RESULT_W-1:0];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** core/serial_adc_conversion_interface.v ***
// Functional notes
// (RQ1) Each convert_start rising edge begins a new conversion.
// (RQ2) Conversion done with convert_start still high: enter sleep until it falls.
// (RQ3) convert_start falling: sample mode, data output driven while it stays low.
// (RQ4) Result bits change on falling shift-clock edges.
// (RQ5) Host samples data output on rising shift-clock edges.
// (RQ6) After all result bits, zeros go out on further clocks.
// (RQ7) Two-channel variant captures 2 config bits on first rising edges.
// (RQ8) Further input bits are ignored until next convert cycle.
// (RQ9) Config in and result out run full duplex on one clock.
// (RQ10) Received config applies to the next conversion, not the current readout.
// (RQ11) Select bit 1: one channel against ground, odd bit picks channel.
// (RQ12) Select bit 0: differential, odd bit swaps polarity.
// (RQ13) Zero code at zero difference; full scale at reference minus one LSB.
// (RQ14) Data output high impedance while convert_start is high.
// (RQ15) Each result is sixteen data bits.
// (RQ16) Host holds convert_start high at least the conversion time.
// (RQ17) Host holds convert_start low at least sixteen shift clocks.
// (RQ18) Result goes out most significant bit first, straight binary.
`timescale 1ns/10ps
`default_nettype none
`include "adc_link_consts.vh"

module serial_adc_conversion_interface #(
  parameter TWO_CHANNEL = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`WB_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire convert_start_i,
  input wire shift_clk_i,
  input wire serial_in_i,
  output reg serial_out_o,
  output reg serial_out_oe_o,
  input wire [`RESULT_W-1:0] analog_channel_zero_i,
  input wire [`RESULT_W-1:0] analog_channel_one_i,
  output reg single_diff_select_o,
  output reg odd_sign_o,
  output reg sleep_o,
  output reg sample_mode_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CONVERT = 2'b01;
  localparam ST_SLEEP = 2'b10;
  localparam ST_SAMPLE = 2'b11;
  // Sized copy, so one reset bit can be picked out
  localparam [2:0] CTRL_RST = `CTRL_RESET;

  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire convert_start_rise;
  wire convert_start_fall;
  wire sck_rise;
  wire sck_fall;
  wire sdi_level;
  wire eng_busy;
  wire eng_done;
  wire [`RESULT_W-1:0] eng_result;
  wire two_ch;
  wire bus_req;
  wire bus_write;
  wire clear_early;
  wire clear_short;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [`RESULT_W-1:0] shreg;
  reg [`RESULT_W-1:0] last_result;
  reg [`RESULT_W-1:0] load_value;
  reg [`BIT_CNT_W-1:0] bits_out;
  reg [`CFG_CNT_W-1:0] cfg_cnt;
  reg [`CFG_W-1:0] cfg_shift;
  reg [`CFG_W-1:0] cfg_pending;
  reg cfg_valid;
  reg [2:0] ctrl;
  reg early_flag;
  reg short_flag;
  reg [31:0] convert_start_count;
  reg [31:0] next_rdata;
  reg next_sgl;
  reg next_odd;

  // Register decode shared by read and write paths
  function reg_hit;
    input [`WB_ADR_W-1:0] adr;
    input [`WB_ADR_W-1:0] offset;
    begin
      reg_hit = (adr[`WB_ADR_W-1:2] == offset[`WB_ADR_W-1:2]);
    end
  endfunction

  // All three pins come from the host's domain
  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({serial_in_i, shift_clk_i, convert_start_i}),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign convert_start_rise = pin_rise[0];
  assign convert_start_fall = pin_fall[0];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign sdi_level = pin_level[2];
  assign two_ch = (TWO_CHANNEL != 0) && ctrl[`CTRL_TWO_CH_BIT];

  // (RQ10) Conversion uses the mux value taken at this start
  convert_start_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(convert_start_rise),
    .two_ch_i(two_ch),
    .sgl_i(next_sgl),
    .odd_i(next_odd),
    .ch_zero_i(analog_channel_zero_i),
    .ch_one_i(analog_channel_one_i),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .result_o(eng_result)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (convert_start_rise) begin
          next_state = ST_CONVERT;
        end else if (convert_start_fall) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_CONVERT: begin
        // (RQ16) Early fall still reads out; flagged for software
        if (convert_start_fall) begin
          next_state = ST_SAMPLE;
        end else if (eng_done) begin
          // (RQ2) Finished while held high
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (convert_start_fall) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // (RQ1) New cycle may start at any time
        if (convert_start_rise) begin
          next_state = ST_CONVERT;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // A result finishing in the same cycle as the fall is not missed
  always @* begin
    load_value = eng_done ? eng_result : last_result;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      sleep_o <= 1'b0;
      sample_mode_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      serial_out_o <= 1'b0;
      shreg <= {`RESULT_W{1'b0}};
      bits_out <= {`BIT_CNT_W{1'b0}};
      last_result <= {`RESULT_W{1'b0}};
    end else begin
      state <= next_state;
      sleep_o <= (next_state == ST_SLEEP);
      sample_mode_o <= (next_state == ST_SAMPLE);
      if (eng_done) begin
        last_result <= eng_result;
      end
      if (convert_start_rise) begin
        // (RQ14) Release the data line while converting
        serial_out_oe_o <= 1'b0;
        serial_out_o <= 1'b0;
      end else if (convert_start_fall) begin
        // (RQ3) Drive the line; (RQ18) MSB ready before first clock
        serial_out_oe_o <= 1'b1;
        serial_out_o <= load_value[`RESULT_W-1];
        shreg <= {load_value[`RESULT_W-2:0], 1'b0};
        bits_out <= {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
      end else if (state == ST_SAMPLE && sck_fall) begin
        // (RQ4) Next bit on falling edge; (RQ6) zeros fill behind
        serial_out_o <= shreg[`RESULT_W-1];
        shreg <= {shreg[`RESULT_W-2:0], 1'b0};
        // (RQ15) Count saturates at sixteen bits
        if (bits_out != `RESULT_W) begin
          bits_out <= bits_out + 1'b1;
        end
      end
    end
  end

  // (RQ9) Input captured on rising edges of the same clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_cnt <= {`CFG_CNT_W{1'b0}};
      cfg_shift <= {`CFG_W{1'b0}};
      cfg_pending <= {`CFG_W{1'b0}};
      cfg_valid <= 1'b0;
    end else if (convert_start_fall) begin
      cfg_cnt <= {`CFG_CNT_W{1'b0}};
    end else if (state == ST_SAMPLE && sck_rise && two_ch) begin
      // (RQ7) First two bits form the word; (RQ8) rest ignored
      if (cfg_cnt < `CFG_W) begin
        cfg_shift <= {cfg_shift[`CFG_W-2:0], sdi_level};
        cfg_cnt <= cfg_cnt + 1'b1;
        if (cfg_cnt == `CFG_W - 1) begin
          cfg_pending <= {cfg_shift[`CFG_W-2:0], sdi_level};
          cfg_valid <= 1'b1;
        end
      end
    end
  end

  // (RQ10) Word reaches the mux only at the next convert start
  // Engine samples this same value, so the new word steers that conversion
  always @* begin
    next_sgl = single_diff_select_o;
    next_odd = odd_sign_o;
    if (convert_start_rise && two_ch && cfg_valid) begin
      next_sgl = cfg_pending[1];
      next_odd = cfg_pending[0];
    end else if (!two_ch) begin
      // Single-input variant: fixed plus/minus pair
      next_sgl = 1'b0;
      next_odd = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      single_diff_select_o <= CTRL_RST[`CTRL_CFG_SGL_BIT];
      odd_sign_o <= 1'b0;
    end else begin
      single_diff_select_o <= next_sgl;
      odd_sign_o <= next_odd;
    end
  end

  // Bus: one wait state, then ack for one cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_req && wb_we_i;
  assign clear_early = bus_write && reg_hit(wb_adr_i, `REG_STATUS) && wb_sel_i[0]
    && wb_dat_i[`STAT_EARLY_BIT];
  assign clear_short = bus_write && reg_hit(wb_adr_i, `REG_STATUS) && wb_sel_i[1]
    && wb_dat_i[`STAT_SHORT_BIT];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (bus_write && reg_hit(wb_adr_i, `REG_CTRL) && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[2:0];
    end
  end

  // Sticky faults of the host; a new event beats a clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      early_flag <= 1'b0;
      short_flag <= 1'b0;
    end else begin
      // (RQ16) Fall before conversion time is up
      if (state == ST_CONVERT && convert_start_fall && !eng_done) begin
        early_flag <= 1'b1;
      end else if (clear_early) begin
        early_flag <= 1'b0;
      end
      // (RQ17) Rise before sixteen bits were clocked
      if (state == ST_SAMPLE && convert_start_rise && bits_out < `RESULT_W) begin
        short_flag <= 1'b1;
      end else if (clear_short) begin
        short_flag <= 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      convert_start_count <= 32'h00000000;
    end else if (eng_done) begin
      convert_start_count <= convert_start_count + 32'h00000001;
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (reg_hit(wb_adr_i, `REG_CTRL)) begin
      next_rdata[2:0] = ctrl;
    end else if (reg_hit(wb_adr_i, `REG_STATUS)) begin
      next_rdata[`STAT_STATE_LSB +: 2] = state;
      next_rdata[`STAT_ACT_CFG_LSB +: 2] = {single_diff_select_o, odd_sign_o};
      next_rdata[`STAT_PEND_CFG_LSB +: 2] = cfg_pending;
      next_rdata[`STAT_CFG_VALID_BIT] = cfg_valid;
      next_rdata[`STAT_EARLY_BIT] = early_flag;
      next_rdata[`STAT_SHORT_BIT] = short_flag;
      next_rdata[`STAT_BITS_LSB +: `BIT_CNT_W] = bits_out;
      next_rdata[`STAT_BITS_LSB + `BIT_CNT_W] = eng_busy;
    end else if (reg_hit(wb_adr_i, `REG_RESULT)) begin
      next_rdata[`RESULT_W-1:0] = last_result;
    end else if (reg_hit(wb_adr_i, `REG_COUNT)) begin
      next_rdata = convert_start_count;
    end
  end

  // Unmapped addresses ack and read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule

`default_nettype wire

// *** test/adc_link_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_link_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic convert_start_i,
  input wire logic shift_clk_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic single_diff_select_o,
  input wire logic odd_sign_o,
  input wire logic sleep_o,
  input wire logic sample_mode_o
);
  logic [9:0] hi_cnt;
  logic [3:0] fall_age;
  logic sck_q;
  // Saturated after reset: no rise was seen, so no timing claim
  always_ff @(posedge clk_i) begin
    sck_q <= shift_clk_i;
    if (rst_i) hi_cnt <= 10'h3FF;
    else if (!convert_start_i) hi_cnt <= 10'h000;
    else if (hi_cnt != 10'h3FF) hi_cnt <= hi_cnt + 10'h001;
    if (rst_i || (sck_q && !shift_clk_i)) fall_age <= 4'h0;
    else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence convert_start_fall_settled;
    $fell(convert_start_i) ##1 !convert_start_i [*6];
  endsequence
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_oe_off_high: assert property (convert_start_i [*7] |-> !serial_out_oe_o)
    else $error("data output driven while convert is high");
  a_oe_on_low: assert property (convert_start_fall_settled |-> serial_out_oe_o)
    else $error("data output not driven after convert fall");
  a_sample_mode_low: assert property (convert_start_fall_settled |-> sample_mode_o)
    else $error("sample mode missing after convert fall");
  a_sleep_after_convert_start: assert property (hi_cnt == 10'h33E |-> sleep_o)
    else $error("no sleep after conversion time");
  a_no_early_sleep: assert property (hi_cnt inside {[10'h007:10'h315]} |-> !sleep_o)
    else $error("sleep before conversion finished");
  a_sleep_ends_low: assert property (!convert_start_i [*7] |-> !sleep_o)
    else $error("sleep kept with convert low");
  a_mux_at_rise: assert property
    ($changed({single_diff_select_o, odd_sign_o}) |-> hi_cnt inside {[10'h001:10'h00A]})
    else $error("mux setting changed away from convert rise");
  a_sdo_on_fall: assert property ($changed(serial_out_o) && serial_out_oe_o
    && $past(serial_out_oe_o) |-> fall_age inside {[4'h1:4'h8]})
    else $error("data bit changed away from a clock fall");
  a_wb_ack_next: assert property (wb_req |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero without ack");
endmodule
bind serial_adc_conversion_interface adc_link_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .convert_start_i(convert_start_i), .shift_clk_i(shift_clk_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .single_diff_select_o(single_diff_select_o),
  .odd_sign_o(odd_sign_o), .sleep_o(sleep_o), .sample_mode_o(sample_mode_o));
`default_nettype wire

// *** test/adc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic convert_start_o,
  output logic sck_o,
  output logic sdi_o
);
  realtime t_next;
  initial begin
    convert_start_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b1;
  end
  // Half of a 125 ns clock, moved only on system edges
  task automatic half();
    t_next = t_next + 62.5;
    while ($realtime < t_next) @(posedge clk_i);
  endtask
  task automatic convert();
    @(posedge clk_i);
    convert_start_o <= 1'b1;
    repeat (900) @(posedge clk_i);
  endtask
  // launch on fall, sample on rise
  task automatic transfer(input logic [1:0] cfg, output logic [17:0] got);
    convert_start_o <= 1'b0;
    sdi_o <= cfg[1];
    repeat (10) @(posedge clk_i);
    t_next = $realtime;
    for (int i = 0; i < 18; i++) begin
      half();
      sck_o <= 1'b1;
      got[17-i] = sdo_i;
      half();
      sck_o <= 1'b0;
      sdi_o <= (i == 0) ? cfg[0] : ~cfg[i%2];
    end
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** test/serial_adc_conversion_interface_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_adc_conversion_interface_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, convert_start, sck, sdi, sdo, sdo_oe, sgl, odd, slp, smp;
  logic [15:0] ch0 = 16'h0000;
  logic [15:0] ch1 = 16'h0000;
  wire sdo_line;
  int miscompares = 0;
  int n_compared = 0;
  always #2 clk_i = ~clk_i;
  // Released line shows the inverse, so a late enable shows as a mismatch
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  serial_adc_conversion_interface uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .convert_start_i(convert_start), .shift_clk_i(sck),
    .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
    .analog_channel_zero_i(ch0), .analog_channel_one_i(ch1), .single_diff_select_o(sgl),
    .odd_sign_o(odd), .sleep_o(slp), .sample_mode_o(smp));
  adc_host_model host (.clk_i(clk_i), .sdo_i(sdo_line), .convert_start_o(convert_start), .sck_o(sck),
    .sdi_o(sdi));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      check("bus timeout", 32'h0, 32'h1);
      end_of_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] code(input logic [1:0] c, input logic [15:0] p,
    input logic [15:0] m);
    if (c[1]) return c[0] ? m : p;
    if (c[0]) return (m > p) ? m - p : 16'h0000;
    return (p > m) ? p - m : 16'h0000;
  endfunction
  initial begin
    logic [1:0] cfg [5] = '{2'b11, 2'b00, 2'b01, 2'b10, 2'b10};
    logic [15:0] a0 [5] = '{16'hC350, 16'hC350, 16'h1234, 16'h3A98, 16'hFFFF};
    logic [15:0] a1 [5] = '{16'h3A98, 16'h3A98, 16'h1234, 16'hC350, 16'h0000};
    logic [1:0] prev;
    logic [17:0] got;
    logic [15:0] e;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", q, 32'h3);
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b0, 8'h00, 32'h0);
    check("ctrl readback", q, 32'h5);
    wb(1'b1, 8'h10, 32'hFF);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
    prev = 2'b10;
    for (int k = 0; k < 5; k++) begin
      ch0 <= a0[k];
      ch1 <= a1[k];
      host.convert();
      check("sleep", slp, 1'b1);
      check("oe while high", sdo_oe, 1'b0);
      check("mux setting", {sgl, odd}, prev);
      host.transfer(cfg[k], got);
      check("sample mode", smp, 1'b1);
      e = code(prev, a0[k], a1[k]);
      check("serial result", got, {e, 2'b00});
      prev = cfg[k];
    end
    wb(1'b0, 8'h08, 32'h0);
    check("result reg", q, {16'h0000, e});
    wb(1'b0, 8'h0C, 32'h0);
    check("count", q, 32'h5);
    end_of_test();
  end
endmodule
`default_nettype wire
